// [rtl/pchb_pkg.sv]
package pchb_pkg;
    // ********************************
    // Configuration header offsets
    // ********************************
    localparam logic [7:0] PCHB_OFS_HDR_KIND = 8'h0c;
    localparam logic [7:0] PCHB_OFS_IO_BASE = 8'h10;
    // ********************************
    // Field layout and fixed values
    // ********************************
    localparam int PCHB_LAYOUT_LSB = 16;
    localparam int PCHB_MFUNC_BIT = 23;
    localparam logic [6:0] PCHB_LAYOUT_CODE = 7'h00;
    localparam logic PCHB_MFUNC_VAL = 1'b0;
    localparam int PCHB_BASE_LSB = 8;
    localparam logic [23:0] PCHB_BASE_RST = 24'h000000;
    localparam logic [31:0] PCHB_IO_BASE_RST = 32'h00000001;
    localparam logic PCHB_IO_FLAG = 1'b1;
    localparam logic [6:0] PCHB_FIXED_LOW = 7'h00;
endpackage

// [rtl/pchb_io_decode.sv]
`timescale 1ns/1ps
// ********************************
// I/O window hit compare
// ********************************
module pchb_io_decode #(
    parameter int WIN_BITS = 8
) (
    input wire logic [31:0] io_addr,
    input wire logic [31-WIN_BITS:0] base_upper,
    output logic hit
);
    // Upper address bits against the stored base; low bits index the block
    assign hit = (io_addr[31:WIN_BITS] == base_upper);
endmodule // pchb_io_decode

// [rtl/pchb_cfg_regs.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Header layout code field, bits 22..16, always reads zero.
// - Multifunction bit 23 always reads zero; single function only.
// - Header kind register readable anytime, nothing in it is writable.
// - I/O base bits 31..8 are read/write storage set by host.
// - Decode a 256-byte I/O block at the stored base.
// - I/O base bits 7..1 always read zero whatever is written.
// - I/O base bit 0 always reads one, marking I/O space.
// - Reset sets the I/O base register to the value one.
// - I/O base register readable anytime by configuration reads.
module pchb_cfg_regs
    import pchb_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic cfg_rd,
    input wire logic cfg_wr,
    input wire logic [7:0] cfg_offset,
    input wire logic [3:0] cfg_be_n,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic io_space_en,
    input wire logic [31:0] io_addr,
    output logic io_hit
);
    import pchb_pkg::*;

    // ********************************
    // Storage and decode
    // ********************************
    logic [23:0] base_ff;
    logic [23:0] nxt_base;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic sel_kind;
    logic sel_base;
    logic raw_hit;
    logic [31:0] kind_word;
    logic [31:0] base_word;
    logic base_wr;
    logic kind_wr;
    logic [3:1] lane_we;

    assign sel_kind = (cfg_offset == PCHB_OFS_HDR_KIND);
    assign sel_base = (cfg_offset == PCHB_OFS_IO_BASE);

    // Write qualifiers; the header kind one feeds only the checks below
    assign base_wr = cfg_wr && sel_base;
    assign kind_wr = cfg_wr && sel_kind;

    // Constant fields built from the package, never stored
    assign kind_word = {8'h00, PCHB_MFUNC_VAL, PCHB_LAYOUT_CODE, 16'h0000};
    assign base_word = {base_ff, PCHB_FIXED_LOW, PCHB_IO_FLAG};

    // Byte lanes 1..3 only; lane 0 holds constants so its write is dropped
    // Lanes update independently, so a partial write leaves the others alone
    genvar g;
    generate
        for (g = 1; g < 4; g++) begin : g_lane
            // Bus enables are active low, flipped here once per lane
            assign lane_we[g] = base_wr && !cfg_be_n[g];
            assign nxt_base[g*8-8 +: 8] = lane_we[g] ?
                cfg_wdata[g*8 +: 8] : base_ff[g*8-8 +: 8];
        end
    endgenerate

    // Read mux; header kind ignores writes entirely
    assign nxt_rdata = !cfg_rd ? rdata_ff :
        sel_kind ? kind_word : sel_base ? base_word : 32'h00000000;

    // Base register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            base_ff <= PCHB_BASE_RST;
        end else begin
            base_ff <= nxt_base;
        end
    end

    // Read data held until next read, so it is stable for the host
    // Cleared by reset so no stale base word survives a reset
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_ff <= 32'h00000000;
        end else begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign cfg_rdata = rdata_ff;

    // ********************************
    // I/O window decode
    // ********************************
    pchb_io_decode #(.WIN_BITS(PCHB_BASE_LSB)) u_dec (
        .io_addr(io_addr),
        .base_upper(base_ff),
        .hit(raw_hit)
    );
    // Gated by the command-register enable kept elsewhere
    assign io_hit = raw_hit && io_space_en;

    // ********************************
    // Checks
    // ********************************
    // Window math by subtraction, so the check does not mirror the compare
    logic [31:0] base_floor;
    logic [31:0] win_offset;
    logic win_inside;

    assign base_floor = {base_ff, 8'h00};
    assign win_offset = io_addr - base_floor;
    assign win_inside = (win_offset < 32'h00000100);

    // One sequence per write lane, one for a skipped lane
    sequence s_base_write;
        cfg_wr && sel_base && !cfg_be_n[1];
    endsequence
    sequence s_base_write_mid;
        base_wr && !cfg_be_n[2];
    endsequence
    sequence s_base_write_top;
        base_wr && !cfg_be_n[3];
    endsequence
    sequence s_lane_skip;
        base_wr && cfg_be_n[1];
    endsequence

    // ********************************
    // Write path checks
    // ********************************
    // Lane 1 lands in the lowest stored byte
    AST_BASE_WRITE: assert property (@(posedge clk) disable iff (!nrst)
        s_base_write |=> base_ff[7:0] == $past(cfg_wdata[15:8]))
        else $error("base byte not written");
    // Lane 2 lands in the middle stored byte
    AST_BASE_WRITE_MID: assert property (@(posedge clk) disable iff (!nrst)
        s_base_write_mid |=> base_ff[15:8] == $past(cfg_wdata[23:16]))
        else $error("middle base byte not written");
    // Lane 3 lands in the top stored byte
    AST_BASE_WRITE_TOP: assert property (@(posedge clk) disable iff (!nrst)
        s_base_write_top |=> base_ff[23:16] == $past(cfg_wdata[31:24]))
        else $error("top base byte not written");

    // Lane 1 left disabled keeps its old byte
    AST_LANE_KEEP: assert property (@(posedge clk) disable iff (!nrst)
        s_lane_skip |=> base_ff[7:0] == $past(base_ff[7:0]))
        else $error("disabled lane changed");
    // No write to the base, no change of the base
    AST_BASE_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !(cfg_wr && sel_base) |=> $stable(base_ff))
        else $error("base changed without write");
    // Header kind writes touch no storage at all
    AST_KIND_WRITE_DROP: assert property (@(posedge clk) disable iff (!nrst)
        kind_wr |=> $stable(base_ff))
        else $error("header kind write changed storage");

    // ********************************
    // Read path checks
    // ********************************
    // Layout code field reads zero
    AST_KIND_READ: assert property (@(posedge clk) disable iff (!nrst)
        cfg_rd && sel_kind |=> cfg_rdata[22:16] == 7'h00)
        else $error("layout code not zero");
    // Same field, placed by the package constants
    AST_LAYOUT_POS: assert property (@(posedge clk) disable iff (!nrst)
        cfg_rd && sel_kind |=> cfg_rdata[PCHB_LAYOUT_LSB +: 7] == PCHB_LAYOUT_CODE)
        else $error("layout code field wrong");
    // Single function, so the multifunction bit stays low
    AST_MFUNC_READ: assert property (@(posedge clk) disable iff (!nrst)
        cfg_rd && sel_kind |=> !cfg_rdata[23])
        else $error("multifunction bit set");
    // Whole header kind dword is constant
    AST_KIND_CONST: assert property (@(posedge clk) disable iff (!nrst)
        cfg_rd && sel_kind |=> cfg_rdata == 32'h00000000)
        else $error("header kind not constant");

    // Fixed low base bits and the reserved bit read zero
    AST_BASE_LOW: assert property (@(posedge clk) disable iff (!nrst)
        cfg_rd && sel_base |=> cfg_rdata[7:1] == 7'h00)
        else $error("low base bits not zero");
    // Space flag marks an I/O window
    AST_IO_FLAG: assert property (@(posedge clk) disable iff (!nrst)
        cfg_rd && sel_base |=> cfg_rdata[0])
        else $error("io flag not one");
    // Stored bits read back as held before the read edge
    AST_BASE_READ: assert property (@(posedge clk) disable iff (!nrst)
        cfg_rd && sel_base && !cfg_wr |=> cfg_rdata[31:8] == $past(base_ff))
        else $error("base readback wrong");
    // A read sharing its cycle with a write returns the old base
    AST_READ_OLD: assert property (@(posedge clk) disable iff (!nrst)
        cfg_rd && base_wr |=> cfg_rdata[31:8] == $past(base_ff))
        else $error("read with write not old value");
    // Read data stands until the next read
    AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !cfg_rd |=> $stable(cfg_rdata))
        else $error("read data changed without read");

    // ********************************
    // Reset and decode checks
    // ********************************
    // First edge out of reset sees the reset base word
    AST_RESET_VAL: assert property (@(posedge clk)
        $rose(nrst) |-> base_word == PCHB_IO_BASE_RST)
        else $error("base not one after reset");
    // A hit only inside the enabled 256-byte window
    AST_DECODE: assert property (@(posedge clk) disable iff (!nrst)
        io_hit |-> io_space_en && win_inside)
        else $error("false io hit");
    // Every enabled address inside the window hits
    AST_DECODE_MISS: assert property (@(posedge clk) disable iff (!nrst)
        io_space_en && win_inside |-> io_hit)
        else $error("missed io hit");
endmodule // pchb_cfg_regs

// [bench/pchb_host_model.sv]
`timescale 1ns/1ps
// ********************************
// Host bridge issuing config and I/O cycles
// ********************************
module pchb_host_model (
    input wire logic clk,
    input wire logic [31:0] cfg_rdata,
    output logic cfg_rd = 1'b0,
    output logic cfg_wr = 1'b0,
    output logic [7:0] cfg_offset = 8'h00,
    output logic [3:0] cfg_be_n = 4'hf,
    output logic [31:0] cfg_wdata = 32'h00000000,
    output logic io_space_en = 1'b0,
    output logic [31:0] io_addr = 32'h00000000
);
    // One-cycle write strobe; data inverted after so stale data never matches
    task automatic wr(input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
        @(posedge clk);
        cfg_offset <= o;
        cfg_be_n <= b;
        cfg_wdata <= d;
        cfg_wr <= 1'b1;
        @(posedge clk);
        cfg_wr <= 1'b0;
        cfg_be_n <= ~b;
        cfg_wdata <= ~d;
    endtask
    // Read data stands until the next read, so two edges is safe
    task automatic rd(input logic [7:0] o, output logic [31:0] d);
        @(posedge clk);
        cfg_offset <= o;
        cfg_rd <= 1'b1;
        @(posedge clk);
        cfg_rd <= 1'b0;
        cfg_offset <= ~o;
        @(posedge clk);
        #1 d = cfg_rdata;
    endtask
    // Present an I/O address; hit is combinational
    task automatic io(input logic e, input logic [31:0] a);
        @(posedge clk);
        io_space_en <= e;
        io_addr <= a;
        @(posedge clk);
        #1;
    endtask
endmodule // pchb_host_model

// [bench/tb_top.sv]
`timescale 1ns/1ps
// ********************************
// Top-level bench
// ********************************
module tb_top;
    import pchb_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic rd, wr, en, hit;
    logic [7:0] ofs;
    logic [3:0] be_n;
    logic [31:0] wd, rdat, ad, got;
    int failures = 0;
    int tests_run = 0;
    // 20 MHz clock
    always #25 clk = ~clk;
    pchb_host_model host (.clk(clk), .cfg_rdata(rdat), .cfg_rd(rd), .cfg_wr(wr),
        .cfg_offset(ofs), .cfg_be_n(be_n), .cfg_wdata(wd), .io_space_en(en), .io_addr(ad));
    pchb_cfg_regs DUT (.clk(clk), .nrst(nrst), .cfg_rd(rd), .cfg_wr(wr), .cfg_offset(ofs),
        .cfg_be_n(be_n), .cfg_wdata(wd), .cfg_rdata(rdat), .io_space_en(en), .io_addr(ad),
        .io_hit(hit));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic conclude;
        $display("Checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // Values straight out of reset, header byte only
    task automatic t_rst_vals;
        host.rd(PCHB_OFS_IO_BASE, got);
        chk("io_base", 32'h00000001, got);
        host.rd(PCHB_OFS_HDR_KIND, got);
        chk("hdr_kind", 32'h00000000, {24'h000000, got[23:16]});
    endtask
    // All ones, then one lane cleared, then a write to the read-only header
    task automatic t_wr_base;
        host.wr(PCHB_OFS_IO_BASE, 4'h0, 32'hffffffff);
        host.rd(PCHB_OFS_IO_BASE, got);
        chk("io_base", 32'hffffff01, got);
        host.wr(PCHB_OFS_IO_BASE, 4'hd, 32'h00000000);
        host.rd(PCHB_OFS_IO_BASE, got);
        chk("io_base", 32'hffff0001, got);
        host.wr(PCHB_OFS_HDR_KIND, 4'h0, 32'hffffffff);
        host.rd(PCHB_OFS_HDR_KIND, got);
        chk("hdr_kind", 32'h00000000, {24'h000000, got[23:16]});
    endtask
    // Window edges and the space enable
    task automatic t_decode;
        host.io(1'b1, 32'hffff00ff);
        chk("io_hit", 32'h1, {31'h0, hit});
        host.io(1'b1, 32'hffff0100);
        chk("io_hit", 32'h0, {31'h0, hit});
        host.io(1'b0, 32'hffff0000);
        chk("io_hit", 32'h0, {31'h0, hit});
    endtask
    // Mid-run reset must restore the base
    task automatic t_rereset;
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        host.rd(PCHB_OFS_IO_BASE, got);
        chk("io_base", 32'h00000001, got);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        t_rst_vals();
        t_wr_base();
        t_decode();
        t_rereset();
        conclude();
    end
    // Hang guard
    initial begin
        repeat (2000) @(posedge clk);
        failures++;
        conclude();
    end
endmodule // tb_top
